// file: bench/hbp_host_model.sv
// Host processor model that drives the multi-mode host bus pins
module hbp_host_model (
	input wire logic clk,
	input wire logic clk_src_bus,
	input wire logic [15:0] dev_data,
	input wire logic dev_oe,
	input wire logic wait_out,
	input wire logic wait_oe,
	output logic bus_clock,
	output logic [15:0] host_data,
	output hbp_pkg::hbp_pins_t pins
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drive_q = 1'b0;
	logic [15:0] wd_q = 16'h0000;
	logic [15:0] float_q = 16'h00FF;

	// --------------------------------------------------------------
	// Clock and data wire
	// --------------------------------------------------------------
	// Bus clock runs only while it is the timing source
	initial begin
		bus_clock = 1'b0;
		forever #100 bus_clock = clk_src_bus ? ~bus_clock : 1'b0;
	end
	// A released bus shows a moving pattern, never the last value
	always @(posedge clk) float_q <= ~float_q;
	assign host_data = dev_oe ? dev_data : (drive_q ? wd_q : float_q);

	// Strobes released, tie levels of the mode applied
	task automatic idle(input hbp_pkg::hbp_mode_t m);
		pins.mode <= m;
		pins.cs_n <= 1'b1;
		pins.addr_lsb_pin <= (m == hbp_pkg::HBP_STROBE_ONE);
		pins.low_write_pin_n <= 1'b1;
		pins.high_write_pin_n <= 1'b1;
		pins.bus_start_pin_n <= (m != hbp_pkg::HBP_GENERIC_ONE);
		pins.read_write_pin <= 1'b1;
		pins.read_pin_n <= 1'b1;
		drive_q <= 1'b0;
	endtask : idle

	initial begin
		pins = '0;
		idle(hbp_pkg::HBP_GENERIC_TWO);
	end

	// One host cycle; held until the port answers or 40 clocks pass, then for slow more clocks, then released
	task automatic access(input logic sel, input logic rd, input logic [16:0] a, input logic [1:0] be,
			input logic [15:0] wd, input int slow, output logic ok, output logic [15:0] rdat);
		ok = 1'b0;
		rdat = 16'h0000;
		pins.cs_n <= ~sel;
		pins.upper_addr_pins <= a[16:1];
		wd_q <= wd;
		drive_q <= ~rd;
		case (pins.mode)
			hbp_pkg::HBP_STROBE_ONE: begin
				pins.addr_lsb_pin <= ~be[0];
				pins.high_write_pin_n <= ~be[1];
				pins.bus_start_pin_n <= 1'b0;
				pins.read_write_pin <= rd;
			end
			hbp_pkg::HBP_STROBE_TWO: begin
				pins.addr_lsb_pin <= a[0];
				pins.low_write_pin_n <= (be != 2'h3);
				pins.read_pin_n <= (be == 2'h3);
				pins.high_write_pin_n <= 1'b0;
				pins.bus_start_pin_n <= 1'b0;
				pins.read_write_pin <= rd;
			end
			hbp_pkg::HBP_GENERIC_ONE: begin
				pins.addr_lsb_pin <= a[0];
				pins.low_write_pin_n <= rd | ~be[0];
				pins.high_write_pin_n <= rd | ~be[1];
				pins.read_write_pin <= ~(rd & be[1]);
				pins.read_pin_n <= ~(rd & be[0]);
			end
			default: begin
				pins.addr_lsb_pin <= a[0];
				pins.low_write_pin_n <= rd;
				pins.high_write_pin_n <= ~be[1];
				pins.read_pin_n <= ~rd;
			end
		endcase
		// Generic wait shows late, so look only after it could have fallen
		if (pins.mode[1])
			repeat (5) @(posedge clk);
		for (int n = 0; n < 40; n++) begin
			@(posedge clk);
			if (wait_oe === 1'b1 && wait_out === pins.mode[1]) begin
				ok = 1'b1;
				break;
			end
		end
		rdat = host_data;
		repeat (slow) @(posedge clk);
		idle(pins.mode);
		for (int n = 0; n < 20 && (dev_oe !== 1'b0 || wait_out !== 1'b1); n++)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask : access
endmodule : hbp_host_model

// file: bench/hbp_host_port_tb_top.sv
// Self-checking testbench of the multi-mode host bus port
module hbp_host_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [16:0] REG_BASE = 17'h1FF80;
	logic clk;
	logic reset_n;
	logic clk_src_bus;
	logic bus_clock;
	hbp_pkg::hbp_pins_t pins;
	logic [15:0] host_data;
	logic [15:0] dout;
	logic doe, wout, woe, mem_req, mem_we, pwr_save;
	logic [16:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [1:0] mem_be;
	logic mem_ack = 1'b0;
	logic [15:0] mem_rdata = 16'h0000;
	logic [35:0] seen = '0;
	int lat = 0;
	int ack_cnt = 0;
	int fails;
	int checks_done;

	// --------------------------------------------------------------
	// Clock, parts and memory side
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	hbp_host_port uut (.clk(clk), .reset_n(reset_n), .host_mode(pins.mode), .clk_src_bus(clk_src_bus),
		.bus_clock_pin(bus_clock), .chip_select_n(pins.cs_n), .addr_lsb_pin(pins.addr_lsb_pin),
		.upper_addr_pins(pins.upper_addr_pins), .low_write_pin_n(pins.low_write_pin_n),
		.high_write_pin_n(pins.high_write_pin_n), .bus_start_pin_n(pins.bus_start_pin_n),
		.read_write_pin(pins.read_write_pin), .read_pin_n(pins.read_pin_n), .host_data_pins_in(host_data),
		.host_data_pins_out(dout), .host_data_pins_oe(doe), .wait_pin_out(wout), .wait_pin_oe(woe),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .pwr_save(pwr_save));
	hbp_host_model host (.clk(clk), .clk_src_bus(clk_src_bus), .dev_data(dout), .dev_oe(doe),
		.wait_out(wout), .wait_oe(woe), .bus_clock(bus_clock), .host_data(host_data), .pins(pins));
	// Memory answers on the third cycle of a request; data follows the address
	always @(posedge clk) begin
		lat <= mem_req ? lat + 1 : 0;
		mem_ack <= (lat == 2);
		mem_rdata <= mem_addr[16:1] ^ 16'h5A5A;
		if (mem_ack)
			ack_cnt <= ack_cnt + 1;
		if (mem_req)
			seen <= {mem_we, mem_be, mem_addr, mem_wdata};
	end

	task automatic check(input string what, input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// Selected host cycle; a missing answer ends the run
	task automatic xfer(input logic rd, input logic [16:0] a, input logic [1:0] be, input logic [15:0] wd,
			input int slow, output logic [15:0] rdat);
		logic ok;
		host.access(1'b1, rd, a, be, wd, slow, ok, rdat);
		check("answer", ok, 1'b1);
		if (ok !== 1'b1)
			final_report();
	endtask : xfer

	task automatic t_reset;
		check("reset outputs", {doe, woe, wout, mem_req, pwr_save}, 5'h04);
		$display("reset test done");
	endtask : t_reset

	task automatic t_modes;
		logic [15:0] wd;
		logic [15:0] rd;
		for (int i = 0; i < 4; i++) begin
			host.idle(hbp_pkg::hbp_mode_t'(i));
			repeat (4) @(posedge clk);
			wd = 16'h3C5A ^ {i[3:0], i[3:0], 8'h00};
			xfer(1'b0, REG_BASE + 17'h74, 2'h3, wd, 0, rd);
			xfer(1'b1, REG_BASE + 17'h74, 2'h3, 16'h0000, i, rd);
			check("register word", rd, wd);
			// Generic two picks the high byte alone by an odd address and the high byte enable
			xfer(1'b0, REG_BASE + ((i == 3) ? 17'h75 : 17'h74), 2'h2, 16'hE700, 0, rd);
			xfer(1'b1, REG_BASE + 17'h74, 2'h3, 16'h0000, 0, rd);
			check("register high byte", rd, {8'hE7, wd[7:0]});
		end
		$display("mode test done");
	endtask : t_modes

	task automatic t_protect;
		logic [15:0] rd;
		xfer(1'b0, REG_BASE + 17'h64, 2'h3, 16'hBEEF, 0, rd);
		xfer(1'b0, REG_BASE + 17'h60, 2'h3, 16'h9C35, 0, rd);
		xfer(1'b1, REG_BASE + 17'h64, 2'h3, 16'h0000, 0, rd);
		check("guarded panel size", rd, 16'h0000);
		xfer(1'b1, REG_BASE + 17'h60, 2'h3, 16'h0000, 0, rd);
		check("guarded mode byte", rd, 16'h0035);
		xfer(1'b0, REG_BASE + 17'h0A, 2'h1, 16'h0001, 0, rd);
		check("power saving", pwr_save, 1'b1);
		xfer(1'b0, REG_BASE + 17'h0A, 2'h3, 16'h6601, 0, rd);
		xfer(1'b0, REG_BASE + 17'h64, 2'h3, 16'hBEEF, 0, rd);
		xfer(1'b1, REG_BASE + 17'h64, 2'h3, 16'h0000, 0, rd);
		check("open panel size", rd, 16'hBEEF);
		xfer(1'b1, REG_BASE + 17'h0A, 2'h3, 16'h0000, 0, rd);
		check("open clock register", rd, 16'h6601);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		check("reset mid run", {pwr_save, doe, woe}, 3'h0);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(1'b1, REG_BASE + 17'h0A, 2'h3, 16'h0000, 0, rd);
		check("register default", rd, 16'h0000);
		$display("guard test done");
	endtask : t_protect

	task automatic t_mem;
		logic [15:0] rd;
		for (int i = 0; i < 3; i++) begin
			host.idle(hbp_pkg::hbp_mode_t'(i));
			repeat (4) @(posedge clk);
			xfer(1'b0, 17'h12468, 2'h2, 16'h7E81, 2, rd);
			check("memory write", seen, {1'b1, 2'h2, 17'h12468, 16'h7E81});
			xfer(1'b1, 17'h0ACE0, 2'h3, 16'h0000, 0, rd);
			check("memory read", rd, 16'h5670 ^ 16'h5A5A);
		end
		$display("memory test done");
	endtask : t_mem

	task automatic t_nocs;
		logic ok;
		logic [15:0] rd;
		int acks;
		acks = ack_cnt;
		host.access(1'b0, 1'b1, 17'h00100, 2'h3, 16'h0000, 0, ok, rd);
		check("unselected answer", {ok, doe}, 2'h0);
		check("unselected memory", ack_cnt - acks, 0);
		$display("select test done");
	endtask : t_nocs

	task automatic t_busclk;
		logic [15:0] rd;
		clk_src_bus <= 1'b1;
		host.idle(hbp_pkg::HBP_GENERIC_TWO);
		repeat (4) @(posedge clk);
		xfer(1'b0, REG_BASE + 17'h74, 2'h3, 16'h1E2D, 0, rd);
		xfer(1'b1, REG_BASE + 17'h74, 2'h3, 16'h0000, 0, rd);
		check("bus clock timed word", rd, 16'h1E2D);
		clk_src_bus <= 1'b0;
		$display("bus clock test done");
	endtask : t_busclk

	// Main sequence
	initial begin
		fails = 0;
		checks_done = 0;
		reset_n = 1'b0;
		clk_src_bus = 1'b0;
		repeat (6) @(posedge clk);
		t_reset();
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_modes();
		t_protect();
		t_mem();
		t_nocs();
		t_busclk();
		final_report();
	end
endmodule : hbp_host_port_tb_top

// file: common/hbp_params.svh
// Constants of the multi-mode host bus port: widths, register indices, reset values
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// --------------------------------------------------------------------
// Widths
// --------------------------------------------------------------------
`define HBP_AW 17
`define HBP_DW 16
`define HBP_REG_COUNT 128

// --------------------------------------------------------------------
// Register window: upper 128 bytes of the address space
// --------------------------------------------------------------------
`define HBP_REG_SPACE 10'h3FF
`define HBP_REG_RST 8'h00

// --------------------------------------------------------------------
// Register indices (byte address = 1FF80h + index)
// --------------------------------------------------------------------
`define HBP_IDX_PWRSAVE 7'h0A
`define HBP_BIT_PWRSAVE 3'h0
`define HBP_IDX_INCLK 7'h0B
`define HBP_IDX_MODE0 7'h61
`define HBP_IDX_PANEL_FIRST 7'h64
`define HBP_IDX_PANEL_LAST 7'h6A

`endif

// file: common/hbp_pkg.sv
// Types of the multi-mode host bus port
package hbp_pkg;

	// ----------------------------------------------------------------
	// Host bus modes and port states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HBP_STROBE_ONE,
		HBP_STROBE_TWO,
		HBP_GENERIC_ONE,
		HBP_GENERIC_TWO
	} hbp_mode_t;

	typedef enum logic [1:0] {
		HBP_IDLE,
		HBP_ACCESS,
		HBP_DONE
	} hbp_state_t;

	// ----------------------------------------------------------------
	// Raw host pins as sampled
	// ----------------------------------------------------------------
	typedef struct packed {
		hbp_mode_t mode;
		logic cs_n;
		logic addr_lsb_pin;
		logic [15:0] upper_addr_pins;
		logic low_write_pin_n;
		logic high_write_pin_n;
		logic bus_start_pin_n;
		logic read_write_pin;
		logic read_pin_n;
		logic [15:0] data;
	} hbp_pins_t;

	// ----------------------------------------------------------------
	// Decoded host cycle, independent of mode
	// ----------------------------------------------------------------
	typedef struct packed {
		logic active;
		logic read;
		logic [1:0] be;
		logic [16:0] addr;
	} hbp_cyc_t;

endpackage : hbp_pkg

// file: design/hbp_decode.sv
// Per-mode meaning of the host control pins, reduced to one common cycle
module hbp_decode (
	input wire hbp_pkg::hbp_pins_t pins,
	output hbp_pkg::hbp_cyc_t cyc
);

	logic wr_any;
	logic rd_any;

	// --------------------------------------------------------------------
	// Pin function mux
	// --------------------------------------------------------------------
	// Tied-high pins of a mode are simply not looked at
	always_comb begin
		wr_any = 1'b0;
		rd_any = 1'b0;
		cyc.active = 1'b0;
		cyc.read = 1'b0;
		cyc.be = 2'h0;
		cyc.addr = {pins.upper_addr_pins, pins.addr_lsb_pin}; // [R4] [R5]
		unique case (pins.mode)
			hbp_pkg::HBP_STROBE_ONE: begin
				// Lowest address pin is the lower data strobe
				cyc.addr = {pins.upper_addr_pins, 1'b0}; // [R3] [R5]
				cyc.active = ~pins.cs_n & ~pins.bus_start_pin_n
					& (~pins.high_write_pin_n | ~pins.addr_lsb_pin); // [R3] [R8] [R9] [R11]
				cyc.read = pins.read_write_pin; // [R10]
				cyc.be = {~pins.high_write_pin_n, ~pins.addr_lsb_pin}; // [R3] [R8]
			end
			hbp_pkg::HBP_STROBE_TWO: begin
				cyc.active = ~pins.cs_n & ~pins.bus_start_pin_n & ~pins.high_write_pin_n; // [R8] [R9] [R11]
				cyc.read = pins.read_write_pin; // [R10]
				// Size bits: byte transfer picks a lane, otherwise a full word
				if ({pins.read_pin_n, pins.low_write_pin_n} == 2'h1) begin // [R7] [R15]
					cyc.be = pins.addr_lsb_pin ? 2'h1 : 2'h2;
				end else begin
					cyc.be = 2'h3;
				end
			end
			hbp_pkg::HBP_GENERIC_ONE: begin
				wr_any = ~pins.low_write_pin_n | ~pins.high_write_pin_n; // [R7] [R8]
				rd_any = ~pins.read_pin_n | ~pins.read_write_pin; // [R10] [R15]
				cyc.active = ~pins.cs_n & (wr_any | rd_any); // [R11]
				cyc.read = rd_any;
				cyc.be = rd_any ? {~pins.read_write_pin, ~pins.read_pin_n}
					: {~pins.high_write_pin_n, ~pins.low_write_pin_n};
			end
			hbp_pkg::HBP_GENERIC_TWO: begin
				wr_any = ~pins.low_write_pin_n; // [R7]
				rd_any = ~pins.read_pin_n; // [R15]
				cyc.active = ~pins.cs_n & (wr_any | rd_any); // [R11]
				cyc.read = rd_any;
				cyc.be = {~pins.high_write_pin_n, ~pins.addr_lsb_pin}; // [R8]
			end
		endcase
	end

endmodule : hbp_decode

// file: design/hbp_host_port.sv
// Multi-mode parallel host bus port: pin sampling, register window and memory requests
//
// How it works
// [R1] Clock, mode 0 and panel timing registers change only in software power saving.
// [R2] Writes to those registers outside power saving are dropped, value kept.
// [R3] Strobe mode one: lowest address pin is the active-low lower data strobe.
// [R4] Other modes: lowest address pin is address bit 0.
// [R5] Upper address pins are address bits 16 to 1 in every mode.
// [R6] Strobe mode two hosts wire the upper half of a 32-bit bus here.
// [R7] Low write pin: size bit 0, low byte write, write enable; tied high otherwise.
// [R8] High write pin: upper strobe, data strobe, high byte write, high byte enable.
// [R9] Bus start pin is address strobe in strobe modes; tied in generic modes.
// [R10] Read/write pin: direction in strobe modes, upper read in generic one.
// [R11] No host access is served unless chip select is low.
// [R12] Bus clock pin is held low when the input clock is the source.
// [R13] Data bus floats at reset and is driven only with read data.
// [R14] Wait pin: transfer ack, size ack one or wait; floats at reset.
// [R15] Read pin: size bit 1, low byte read, read command; tied high otherwise.
// [R16] Reset returns registers to defaults and outputs to inactive states.
`include "hbp_params.svh"

module hbp_host_port (
	input wire logic clk,
	input wire logic reset_n,
	input wire hbp_pkg::hbp_mode_t host_mode,
	input wire logic clk_src_bus,
	input wire logic bus_clock_pin,
	input wire logic chip_select_n,
	input wire logic addr_lsb_pin,
	input wire logic [15:0] upper_addr_pins,
	input wire logic low_write_pin_n,
	input wire logic high_write_pin_n,
	input wire logic bus_start_pin_n,
	input wire logic read_write_pin,
	input wire logic read_pin_n,
	input wire logic [15:0] host_data_pins_in,
	output logic [15:0] host_data_pins_out,
	output logic host_data_pins_oe,
	output logic wait_pin_out,
	output logic wait_pin_oe,
	output logic mem_req,
	output logic mem_we,
	output logic [16:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic [1:0] mem_be,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic pwr_save
);

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	typedef struct packed {
		hbp_pkg::hbp_pins_t pin1;
		hbp_pkg::hbp_pins_t pin2;
		logic bclk1;
		logic bclk2;
		logic bclk3;
		logic src1;
		logic src2;
		hbp_pkg::hbp_state_t state;
		hbp_pkg::hbp_cyc_t cyc;
		logic [`HBP_REG_COUNT-1:0][7:0] regs;
		logic [15:0] dout;
		logic dout_oe;
		logic wait_out;
		logic wait_oe;
		logic mem_req;
		logic mem_we;
		logic [16:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [1:0] mem_be;
	} hbp_port_state_t;

	hbp_port_state_t q;
	hbp_port_state_t d;
	hbp_pkg::hbp_pins_t pins_now;
	hbp_pkg::hbp_cyc_t cyc_now;
	logic take;
	logic pwr_on;
	logic strobe_mode;

	// Restricted registers: input clock, mode 0 and the panel block
	function automatic logic is_locked(input logic [6:0] idx);
		is_locked = (idx == `HBP_IDX_INCLK) || (idx == `HBP_IDX_MODE0)
			|| ((idx >= `HBP_IDX_PANEL_FIRST) && (idx <= `HBP_IDX_PANEL_LAST));
	endfunction : is_locked

	// --------------------------------------------------------------------
	// Pin gathering and decode
	// --------------------------------------------------------------------
	always_comb begin
		pins_now.mode = host_mode;
		pins_now.cs_n = chip_select_n;
		pins_now.addr_lsb_pin = addr_lsb_pin;
		pins_now.upper_addr_pins = upper_addr_pins;
		pins_now.low_write_pin_n = low_write_pin_n;
		pins_now.high_write_pin_n = high_write_pin_n;
		pins_now.bus_start_pin_n = bus_start_pin_n;
		pins_now.read_write_pin = read_write_pin;
		pins_now.read_pin_n = read_pin_n;
		pins_now.data = host_data_pins_in;
	end

	hbp_decode u_decode (
		.pins(q.pin2),
		.cyc(cyc_now)
	);

	// Bus clock is only an edge source; in input-clock mode it stands low
	assign take = ~q.src2 | (q.bclk2 & ~q.bclk3); // [R12]
	assign pwr_on = q.regs[`HBP_IDX_PWRSAVE][`HBP_BIT_PWRSAVE];
	assign strobe_mode = (q.pin2.mode == hbp_pkg::HBP_STROBE_ONE) || (q.pin2.mode == hbp_pkg::HBP_STROBE_TWO);

	// --------------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------------
	always_comb begin
		d = q;
		d.pin1 = pins_now;
		d.pin2 = q.pin1;
		d.bclk1 = bus_clock_pin;
		d.bclk2 = q.bclk1;
		d.bclk3 = q.bclk2;
		// Source strap is a pin too, so it is synchronised like the rest
		d.src1 = clk_src_bus;
		d.src2 = q.src1;
		unique case (q.state)
			hbp_pkg::HBP_IDLE: begin
				if (take && cyc_now.active) begin // [R11]
					d.cyc = cyc_now;
					if (cyc_now.addr[16:7] == `HBP_REG_SPACE) begin
						// Register window answers at once
						for (int i = 0; i < 2; i++) begin
							if (cyc_now.read) begin
								d.dout[i*8 +: 8] = q.regs[{cyc_now.addr[6:1], i[0]}];
							end else if (cyc_now.be[i] && (!is_locked({cyc_now.addr[6:1], i[0]}) || pwr_on)) begin // [R1] [R2]
								d.regs[{cyc_now.addr[6:1], i[0]}] = q.pin2.data[i*8 +: 8];
							end
						end
						d.state = hbp_pkg::HBP_DONE;
					end else begin
						d.mem_req = 1'b1;
						d.mem_we = ~cyc_now.read;
						d.mem_addr = cyc_now.addr; // [R5]
						d.mem_wdata = q.pin2.data;
						d.mem_be = cyc_now.be;
						d.state = hbp_pkg::HBP_ACCESS;
					end
				end
			end
			hbp_pkg::HBP_ACCESS: begin
				if (mem_ack) begin
					d.mem_req = 1'b0;
					d.dout = mem_rdata;
					d.state = hbp_pkg::HBP_DONE;
				end
			end
			hbp_pkg::HBP_DONE: begin
				// Hold the answer until the host lets go of the strobe
				if (!cyc_now.active) begin
					d.state = hbp_pkg::HBP_IDLE;
				end
			end
		endcase
		// Drive data only while read data stands ready
		d.dout_oe = (d.state == hbp_pkg::HBP_DONE) && d.cyc.read && cyc_now.active; // [R13]
		// Wait pin drives only while selected; acks in strobe modes, waits in generic
		d.wait_oe = ~q.pin2.cs_n; // [R14]
		if (strobe_mode) begin
			d.wait_out = ~(d.state == hbp_pkg::HBP_DONE); // [R14]
		end else begin
			d.wait_out = ~(cyc_now.active && (d.state != hbp_pkg::HBP_DONE)); // [R14]
		end
	end

	// --------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------
	// Everything resets to defaults, outputs float or idle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0; // [R16]
			q.pin1.cs_n <= 1'b1;
			q.pin2.cs_n <= 1'b1;
			q.wait_out <= 1'b1;
			q.state <= hbp_pkg::HBP_IDLE;
			for (int r = 0; r < `HBP_REG_COUNT; r++) begin
				q.regs[r] <= `HBP_REG_RST;
			end
		end else begin
			q <= d;
		end
	end

	assign host_data_pins_out = q.dout;
	assign host_data_pins_oe = q.dout_oe;
	assign wait_pin_out = q.wait_out;
	assign wait_pin_oe = q.wait_oe;
	assign mem_req = q.mem_req;
	assign mem_we = q.mem_we;
	assign mem_addr = q.mem_addr;
	assign mem_wdata = q.mem_wdata;
	assign mem_be = q.mem_be;
	assign pwr_save = q.regs[`HBP_IDX_PWRSAVE][`HBP_BIT_PWRSAVE];

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_mode0_locked;
		!pwr_on |=> $stable(q.regs[`HBP_IDX_MODE0]);
	endproperty
	a_mode0_locked: assert property (p_mode0_locked) else $error("mode 0 changed outside power saving"); // [R1]

	property p_locked_write_dropped;
		(q.state == hbp_pkg::HBP_IDLE) && take && cyc_now.active && !cyc_now.read && !pwr_on
			&& (cyc_now.addr[16:7] == `HBP_REG_SPACE) && is_locked({cyc_now.addr[6:1], 1'b0})
			|=> q.regs[{q.cyc.addr[6:1], 1'b0}] == $past(q.regs[{cyc_now.addr[6:1], 1'b0}]);
	endproperty
	a_locked_write_dropped: assert property (p_locked_write_dropped) else $error("locked register written"); // [R2]

	property p_no_select_no_access;
		(q.state == hbp_pkg::HBP_IDLE) && q.pin2.cs_n |=> (q.state == hbp_pkg::HBP_IDLE) && !q.mem_req;
	endproperty
	a_no_select_no_access: assert property (p_no_select_no_access) else $error("access without chip select"); // [R11]

	property p_data_only_on_read;
		q.dout_oe |-> q.cyc.read && (q.state == hbp_pkg::HBP_DONE);
	endproperty
	a_data_only_on_read: assert property (p_data_only_on_read) else $error("data bus driven outside read"); // [R13]

	property p_data_release;
		(q.state == hbp_pkg::HBP_DONE) && !cyc_now.active |=> !q.dout_oe && (q.state == hbp_pkg::HBP_IDLE);
	endproperty
	a_data_release: assert property (p_data_release) else $error("data bus held after strobe release"); // [R13]

	property p_wait_float;
		q.pin2.cs_n |=> !q.wait_oe;
	endproperty
	a_wait_float: assert property (p_wait_float) else $error("wait pin driven while deselected"); // [R14]

	property p_strobe_ack;
		strobe_mode && (q.state == hbp_pkg::HBP_DONE) && $stable(q.pin2.mode) |-> !q.wait_out;
	endproperty
	a_strobe_ack: assert property (p_strobe_ack) else $error("no acknowledge in strobe mode"); // [R14]

	property p_generic_wait;
		!strobe_mode && (q.state == hbp_pkg::HBP_ACCESS) && $past(cyc_now.active) && $stable(q.pin2.mode)
			|-> !q.wait_out;
	endproperty
	a_generic_wait: assert property (p_generic_wait) else $error("wait not asserted during access"); // [R14]

	property p_mem_addr;
		$rose(q.mem_req) |-> q.mem_addr[16:1] == $past(q.pin2.upper_addr_pins);
	endproperty
	a_mem_addr: assert property (p_mem_addr) else $error("memory address not from upper pins"); // [R5]

	property p_lsb_strobe;
		$rose(q.mem_req) && ($past(q.pin2.mode) == hbp_pkg::HBP_STROBE_ONE) |-> !q.mem_addr[0]
			&& (q.mem_be[0] == !$past(q.pin2.addr_lsb_pin));
	endproperty
	a_lsb_strobe: assert property (p_lsb_strobe) else $error("lower data strobe misread"); // [R3]

endmodule : hbp_host_port
